/* qsc_cfg.svh */
// constants of the quad sample convert sequencer
`ifndef QSC_CFG_SVH
`define QSC_CFG_SVH

`define QSC_CODE_W        12
`define QSC_NUM_CH        4
`define QSC_LAST_CH       2'h3
`define QSC_CODE_STEPS    4096
`define QSC_CODE_POS_FS   12'h7ff
`define QSC_CODE_NEG_FS   12'h800
`define QSC_CODE_ZERO     12'h000
`define QSC_CODE_MINUS1   12'hfff
`define QSC_TRIAL_MSB     12'h800
`define QSC_CH_CYCLES     5'h12
`define QSC_BIT_CYCLES    5'h0c
`define QSC_SEQ_EDGES     78
`define QSC_CLK_PERIOD_NS 10
`define QSC_SEQ_MAX_NS    32500
`define QSC_CONV_CLK_NS   400
`define QSC_SEQ_MAX_CYC   (`QSC_SEQ_MAX_NS / `QSC_CONV_CLK_NS)
`define QSC_FIFO_DEPTH    16

`endif

/* qsc_pkg.sv */
// types of the quad sample convert sequencer
package qsc_pkg;
  typedef enum logic [1:0] {QSC_IDLE, QSC_CONV, QSC_PUSH, QSC_DRAIN} qsc_state_t;
  typedef logic [1:0]  qsc_chan_t;
  typedef logic [11:0] qsc_code_t;
endpackage

/* qsc_fifo.sv */
// result fifo with valid/ready on both sides
`timescale 1ns/10ps
module qsc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
    end else if (push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_ptr_r <= '0;
    end else if (pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule // qsc_fifo

/* qsc_sequencer.sv */
// four channel simultaneous sampling convert sequencer with implicit readout
`timescale 1ns/10ps
`include "qsc_cfg.svh"
module qsc_sequencer (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             sample_trigger_n,
  input  wire qsc_pkg::qsc_code_t analog_input_one,
  input  wire qsc_pkg::qsc_code_t analog_input_two,
  input  wire qsc_pkg::qsc_code_t analog_input_three,
  input  wire qsc_pkg::qsc_code_t analog_input_four,
  input  wire logic             chip_select_n,
  input  wire logic             read_strobe_n,
  output qsc_pkg::qsc_code_t    result_bus_out,
  output logic                  result_bus_oe,
  output logic                  done_flag_n,
  output logic                  hold_mode
);
  import qsc_pkg::*;

  qsc_state_t state_r;
  qsc_chan_t  conv_ch_r;
  qsc_chan_t  store_idx_r;
  qsc_chan_t  rd_ptr_r;
  logic [4:0] bit_cnt_r;
  qsc_code_t  sar_r;
  qsc_code_t  held_r [`QSC_NUM_CH];
  qsc_code_t  result_r [`QSC_NUM_CH];
  qsc_code_t  track_in [`QSC_NUM_CH];
  logic       trig_s1_r;
  logic       trig_s2_r;
  logic       trig_s3_r;
  logic       trig_rise;
  logic       rd_act;
  logic       rd_act_q_r;
  logic       rd_fall;
  logic       rd_rise;
  logic       first_read_r;
  logic       done_flag_n_r;
  logic       hold_mode_r;
  logic       result_bus_oe_r;
  qsc_code_t  result_bus_r;
  qsc_code_t  trial;
  qsc_code_t  held_ob;
  qsc_code_t  conv_code;
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  qsc_code_t  fifo_out_data;
  logic       store;
  logic       last_store;
  logic [15:0] seq_cyc_r;

  assign track_in[0] = analog_input_one;
  assign track_in[1] = analog_input_two;
  assign track_in[2] = analog_input_three;
  assign track_in[3] = analog_input_four;

  // trigger synchroniser and rising edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trig_s1_r <= 1'b1;
      trig_s2_r <= 1'b1;
      trig_s3_r <= 1'b1;
    end else begin
      trig_s1_r <= sample_trigger_n;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end
  assign trig_rise = trig_s2_r & ~trig_s3_r;

  // track/hold per channel
  genvar gi;
  generate
    for (gi = 0; gi < `QSC_NUM_CH; gi++) begin : g_hold
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          held_r[gi] <= `QSC_CODE_ZERO;
        end else if (!hold_mode_r) begin
          held_r[gi] <= track_in[gi];
        end else if (trig_rise && state_r == QSC_IDLE) begin
          held_r[gi] <= track_in[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hold_mode_r <= 1'b0;
    end else if (trig_rise && state_r == QSC_IDLE) begin
      hold_mode_r <= 1'b1;
    end else if (last_store) begin
      hold_mode_r <= 1'b0;
    end
  end

  // successive approximation in offset binary
  assign held_ob   = {~held_r[conv_ch_r][11], held_r[conv_ch_r][10:0]};
  assign trial     = sar_r | (`QSC_TRIAL_MSB >> bit_cnt_r);
  assign conv_code = {~sar_r[11], sar_r[10:0]};

  // conversion sequence
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r   <= QSC_IDLE;
      conv_ch_r <= 2'h0;
      bit_cnt_r <= 5'h00;
      sar_r     <= `QSC_CODE_ZERO;
    end else begin
      unique case (state_r)
        QSC_IDLE: begin
          if (trig_rise) begin
            state_r   <= QSC_CONV;
            conv_ch_r <= 2'h0;
            bit_cnt_r <= 5'h00;
            sar_r     <= `QSC_CODE_ZERO;
          end
        end
        QSC_CONV: begin
          if (bit_cnt_r < `QSC_BIT_CYCLES && trial <= held_ob) begin
            sar_r <= trial;
          end
          if (bit_cnt_r == `QSC_CH_CYCLES - 5'h01) begin
            state_r <= QSC_PUSH;
          end else begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
        end
        QSC_PUSH: begin
          if (fifo_in_ready) begin
            if (conv_ch_r == `QSC_LAST_CH) begin
              state_r <= QSC_DRAIN;
            end else begin
              state_r   <= QSC_CONV;
              conv_ch_r <= conv_ch_r + 2'h1;
              bit_cnt_r <= 5'h00;
              sar_r     <= `QSC_CODE_ZERO;
            end
          end
        end
        QSC_DRAIN: begin
          if (last_store) begin
            state_r <= QSC_IDLE;
          end
        end
      endcase
    end
  end

  assign fifo_in_valid  = (state_r == QSC_PUSH);
  assign fifo_out_ready = ~rd_act;
  assign store          = fifo_out_valid & fifo_out_ready;
  assign last_store     = store & (store_idx_r == `QSC_LAST_CH);

  qsc_fifo #(
    .WIDTH (`QSC_CODE_W),
    .DEPTH (`QSC_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (conv_code),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // result registers filled in channel order
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      store_idx_r <= 2'h0;
    end else if (trig_rise && state_r == QSC_IDLE) begin
      store_idx_r <= 2'h0;
    end else if (store) begin
      store_idx_r <= store_idx_r + 2'h1;
    end
  end

  generate
    for (gi = 0; gi < `QSC_NUM_CH; gi++) begin : g_result
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          result_r[gi] <= `QSC_CODE_ZERO;
        end else if (store && store_idx_r == 2'(gi)) begin
          result_r[gi] <= fifo_out_data;
        end
      end
    end
  endgenerate

  // host read cycle detection
  assign rd_act  = ~chip_select_n & ~read_strobe_n;
  assign rd_fall = rd_act & ~rd_act_q_r;
  assign rd_rise = ~rd_act & rd_act_q_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_act_q_r <= 1'b0;
    end else begin
      rd_act_q_r <= rd_act;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      done_flag_n_r <= 1'b1;
    end else if (last_store) begin
      done_flag_n_r <= 1'b0;
    end else if (rd_fall && first_read_r) begin
      done_flag_n_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      first_read_r <= 1'b0;
    end else if (last_store) begin
      first_read_r <= 1'b1;
    end else if (rd_fall) begin
      first_read_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_ptr_r <= 2'h0;
    end else if (trig_rise) begin
      rd_ptr_r <= 2'h0;
    end else if (rd_rise && rd_ptr_r != `QSC_LAST_CH) begin
      rd_ptr_r <= rd_ptr_r + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      result_bus_oe_r <= 1'b0;
      result_bus_r    <= `QSC_CODE_ZERO;
    end else begin
      result_bus_oe_r <= rd_act;
      result_bus_r    <= rd_act ? result_r[rd_ptr_r] : `QSC_CODE_ZERO;
    end
  end

  // trigger to done cycle counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      seq_cyc_r <= 16'h0000;
    end else if (trig_rise && state_r == QSC_IDLE) begin
      seq_cyc_r <= 16'h0001;
    end else if (state_r != QSC_IDLE) begin
      seq_cyc_r <= seq_cyc_r + 16'h0001;
    end
  end

  assign result_bus_out = result_bus_r;
  assign result_bus_oe  = result_bus_oe_r;
  assign done_flag_n    = done_flag_n_r;
  assign hold_mode      = hold_mode_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_trig_hold_on: assert property (trig_rise && state_r == QSC_IDLE |=> hold_mode_r)
    else $error("hold not entered on trigger");
  a_hold_kept: assert property (state_r != QSC_IDLE && !last_store |=> hold_mode_r)
    else $error("hold released mid sequence");
  a_first_channel: assert property (trig_rise && state_r == QSC_IDLE
    |=> state_r == QSC_CONV && conv_ch_r == 2'h0)
    else $error("sequence did not start on channel one");
  a_store_order: assert property (store && store_idx_r != `QSC_LAST_CH
    |=> store_idx_r == $past(store_idx_r) + 2'h1)
    else $error("results stored out of order");
  a_done_cause: assert property ($fell(done_flag_n_r) |-> $past(last_store))
    else $error("done fell without fourth store");
  a_done_release: assert property (rd_fall && first_read_r && !last_store
    |=> done_flag_n_r)
    else $error("done not released by first read");
  a_ptr_rearm: assert property (trig_rise |=> rd_ptr_r == 2'h0)
    else $error("pointer not rearmed");
  a_ptr_stop: assert property (rd_ptr_r == `QSC_LAST_CH && !trig_rise
    |=> rd_ptr_r == `QSC_LAST_CH)
    else $error("pointer moved past register four");
  a_bus_drive: assert property (result_bus_oe_r == $past(rd_act, 1))
    else $error("bus enable not tied to read cycle");
  a_seq_edges: assert property (trig_rise && state_r == QSC_IDLE && done_flag_n_r
    && fifo_out_ready [*1] ##1 !rd_act [*8]
    |-> ##70 $fell(done_flag_n_r))
    else $error("sequence length wrong");
  a_seq_limit: assert property (seq_cyc_r <= 16'(`QSC_SEQ_MAX_CYC))
    else $error("sequence exceeded time limit");

  c_full_seq: cover property (trig_rise ##[1:100] $fell(done_flag_n_r));
  c_four_reads: cover property (rd_rise && rd_ptr_r == 2'h2 ##[1:50] rd_rise);
  c_retrigger: cover property (trig_rise && state_r == QSC_CONV);
  c_first_read: cover property (rd_fall && first_read_r);
endmodule // qsc_sequencer

/* qsc_host_model.sv */
// host bus model: trigger strobe and read cycles
`timescale 1ns/10ps
module qsc_host_model (
  input  wire logic               ref_clk,
  input  wire qsc_pkg::qsc_code_t result_bus_out,
  input  wire logic               result_bus_oe,
  output logic                    sample_trigger_n,
  output logic                    chip_select_n,
  output logic                    read_strobe_n
);
  import qsc_pkg::*;
  qsc_code_t last_r;
  qsc_code_t bus_seen;

  // released bus shows inverse of last driven word
  always_ff @(posedge ref_clk) begin
    if (result_bus_oe) begin
      last_r <= result_bus_out;
    end
  end
  assign bus_seen = result_bus_oe ? result_bus_out : ~last_r;

  initial begin
    sample_trigger_n = 1'b1;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
  end

  // clean strobe-shaped low pulse, unrelated to device timing
  task automatic pulse_trigger();
    @(negedge ref_clk);
    sample_trigger_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    sample_trigger_n = 1'b1;
  endtask

  // one read cycle, only called once done is low
  task automatic read_word(output qsc_code_t data);
    int n;
    n = 0;
    @(negedge ref_clk);
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (result_bus_oe !== 1'b1 && n < 8);
    data = bus_seen;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
  endtask

  // only one of select and strobe low
  task automatic half_select(input logic cs_n, input logic rd_n, output logic seen);
    seen = 1'b0;
    @(negedge ref_clk);
    chip_select_n = cs_n;
    read_strobe_n = rd_n;
    repeat (4) begin
      @(negedge ref_clk);
      seen = seen | result_bus_oe;
    end
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
  endtask
endmodule // qsc_host_model

/* tb.sv */
// testbench of the quad sample convert sequencer
`timescale 1ns/10ps
module tb;
  import qsc_pkg::*;
  logic      ref_clk;
  logic      reset;
  qsc_code_t ain [4];
  qsc_code_t result_bus_out;
  logic      result_bus_oe;
  logic      done_flag_n;
  logic      hold_mode;
  logic      sample_trigger_n;
  logic      chip_select_n;
  logic      read_strobe_n;
  int        mismatches;
  int        tests_run;

  qsc_sequencer dut (
    .ref_clk(ref_clk), .reset(reset), .sample_trigger_n(sample_trigger_n),
    .analog_input_one(ain[0]), .analog_input_two(ain[1]),
    .analog_input_three(ain[2]), .analog_input_four(ain[3]),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe),
    .done_flag_n(done_flag_n), .hold_mode(hold_mode)
  );

  qsc_host_model host (
    .ref_clk(ref_clk), .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe),
    .sample_trigger_n(sample_trigger_n), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n)
  );

  always #5 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // trigger, move inputs once held, wait for done
  task automatic run_seq(input qsc_code_t c [4]);
    int   n;
    logic held;
    n = 0;
    held = 1'b0;
    @(negedge ref_clk);
    ain = c;
    host.pulse_trigger();
    while (done_flag_n === 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
      if (hold_mode === 1'b1) begin
        held = 1'b1;
        foreach (ain[i]) ain[i] = ~c[i];
      end else if (held && done_flag_n === 1'b1) begin
        check("hold_mode in sequence", 12'h001, 12'(hold_mode));
      end
    end
    check("hold seen", 12'h001, 12'(held));
    check("done_flag_n", 12'h000, 12'(done_flag_n));
    check("hold_mode at done", 12'h000, 12'(hold_mode));
    check("sequence edges", 12'h050, 12'(n));
  endtask

  task automatic read_check(input qsc_code_t c [4], input int cnt);
    qsc_code_t d;
    for (int i = 0; i < cnt; i++) begin
      host.read_word(d);
      check("result word", c[i > 3 ? 3 : i], d);
      if (i == 0) check("done after read", 12'h001, 12'(done_flag_n));
    end
    @(negedge ref_clk);
    check("bus enable idle", 12'h000, 12'(result_bus_oe));
  endtask

  task automatic t_reset();
    check("done_flag_n", 12'h001, 12'(done_flag_n));
    check("hold_mode", 12'h000, 12'(hold_mode));
    check("bus enable", 12'h000, 12'(result_bus_oe));
    $display("test reset done");
  endtask

  task automatic t_select();
    logic seen;
    host.half_select(1'b0, 1'b1, seen);
    check("oe select only", 12'h000, 12'(seen));
    host.half_select(1'b1, 1'b0, seen);
    check("oe strobe only", 12'h000, 12'(seen));
    $display("test select done");
  endtask

  task automatic t_codes();
    qsc_code_t c [4];
    c = '{12'h7ff, 12'h800, 12'hfff, 12'h000};
    run_seq(c);
    read_check(c, 5);
    $display("test codes done");
  endtask

  task automatic t_rearm();
    qsc_code_t a [4];
    qsc_code_t b [4];
    a = '{12'h123, 12'h456, 12'h789, 12'habc};
    b = '{12'h321, 12'h654, 12'h987, 12'hcba};
    run_seq(a);
    read_check(a, 2);
    run_seq(b);
    read_check(b, 4);
    $display("test rearm done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    ain = '{default: 12'h000};
    mismatches = 0;
    tests_run = 0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    t_reset();
    t_select();
    t_codes();
    t_rearm();
    conclude();
  end

  // tests take about 300 cycles; allow ten thousand
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule // tb
